// ### verilog/dssc_top.sv
// Drive state machine, status word and quick stop / fault reaction control.
// Assumes an object-dictionary port already decoded from the fieldbus stack,
// synchronous to core_clk_i, and feedback from the motion core on that clock.
//
// How it works
// - Status bits 0-6 carry drive state flags, bit 7 warning
// - Bit 10 target reached, bit 12 per mode
// - Bit 13 following or homing error only
// - Not ready and switch-on-disabled patterns
// - Ready, switched on, enabled patterns
// - Quick stop clears bit 5, keeps enabled
// - Fault reaction 1111, settled fault 1000
// - Quick stop option 0 coasts, default
// - Options 1/2 ramp then switch-on-disabled
// - Options 3/4 ramp then stay enabled
// - Fault option 0 freewheels, default
// - Fault options 1/2 ramp then fault state
// - Control word 2 quick stops, then disabled except options 3/4
`timescale 1ns/1ps
module dssc_top
	import dssc_pkg::*;
#(
	parameter int MS_CYCLES = DSSC_MS_CYCLES,
	parameter int SPEED_W = 16
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Object dictionary access
	input wire logic od_wr_i,
	input wire logic od_rd_i,
	input wire logic [15:0] od_index_i,
	input wire logic [31:0] od_wdata_i,
	output logic [31:0] od_rdata_o,
	output logic od_ack_o,
	output logic od_err_o,
	// Drive events and feedback
	input wire logic init_done_i,
	input wire logic fault_i,
	input wire logic fault_reset_i,
	input wire dssc_fb_t fb_i,
	input wire logic [SPEED_W-1:0] speed_i,
	// Power stage control
	output logic power_on_o,
	output logic brake_ramp_o,
	output logic [SPEED_W-1:0] speed_limit_o,
	output logic [15:0] status_word_o
);
	dssc_state_t state_reg, state_next;
	logic [31:0] slow_decel_time_ms_reg; // Slow deceleration time
	logic [31:0] fast_stop_time_ms_reg; // Fast stop time
	logic [15:0] quick_stop_option_reg; // Quick stop option code
	logic [15:0] fault_reaction_option_reg; // Fault reaction option code
	logic cw_wr; // Control word written this cycle
	logic [15:0] cw;
	logic qs_hold_reg; // Stay enabled after the quick stop ramp
	logic ramp_start, ramp_coast, ramp_busy, ramp_done;
	logic [31:0] ramp_time;
	dssc_stop_t qs_act, fr_act, act;
	logic [15:0] sw_next;
	logic [SPEED_W-1:0] ramp_speed;

	assign cw_wr = od_wr_i && od_index_i == DSSC_IDX_CTRL;
	assign cw = od_wdata_i[15:0];

	// Decode quick stop option; reserved codes coast like the default
	always_comb begin
		case (quick_stop_option_reg)
			16'h0001, 16'h0003: qs_act = DSSC_STOP_FAST;
			16'h0002, 16'h0004: qs_act = DSSC_STOP_SLOW;
			default: qs_act = DSSC_STOP_COAST;
		endcase
	end

	// Decode fault reaction option; reserved codes freewheel
	always_comb begin
		case (fault_reaction_option_reg)
			16'h0001: fr_act = DSSC_STOP_FAST;
			16'h0002: fr_act = DSSC_STOP_SLOW;
			default: fr_act = DSSC_STOP_COAST;
		endcase
	end

	// Next state; faults take priority over any control word
	always_comb begin
		state_next = state_reg;
		ramp_start = 1'b0;
		act = DSSC_STOP_COAST;
		case (state_reg)
			DSSC_NOT_READY: begin
				if (init_done_i) begin
					state_next = DSSC_SW_DISABLED;
				end
			end
			DSSC_SW_DISABLED: begin
				if (cw_wr && cw == DSSC_CW_SHUTDOWN) begin
					state_next = DSSC_READY;
				end
			end
			DSSC_READY: begin
				if (cw_wr && cw == DSSC_CW_SWITCH_ON) begin
					state_next = DSSC_SWITCHED_ON;
				end else if (cw_wr && cw == DSSC_CW_QSTOP) begin
					state_next = DSSC_SW_DISABLED;
				end
			end
			DSSC_SWITCHED_ON: begin
				if (cw_wr && cw == DSSC_CW_ENABLE) begin
					state_next = DSSC_OP_ENABLED;
				end else if (cw_wr && cw == DSSC_CW_SHUTDOWN) begin
					state_next = DSSC_READY;
				end else if (cw_wr && cw == DSSC_CW_QSTOP) begin
					state_next = DSSC_SW_DISABLED;
				end
			end
			DSSC_OP_ENABLED: begin
				if (cw_wr && cw == DSSC_CW_SWITCH_ON) begin
					state_next = DSSC_SWITCHED_ON;
				end else if (cw_wr && cw == DSSC_CW_SHUTDOWN) begin
					state_next = DSSC_READY;
				end else if (cw_wr && cw == DSSC_CW_QSTOP) begin
					state_next = DSSC_QSTOP;
					act = qs_act;
					ramp_start = 1'b1;
				end
			end
			DSSC_QSTOP: begin
				// Held stop leaves only on an explicit enable
				if (ramp_done && !qs_hold_reg) begin
					state_next = DSSC_SW_DISABLED;
				end else if (qs_hold_reg && !ramp_busy && cw_wr && cw == DSSC_CW_ENABLE) begin
					state_next = DSSC_OP_ENABLED;
				end
			end
			DSSC_FAULT_REACT: begin
				if (ramp_done) begin
					state_next = DSSC_FAULT;
				end
			end
			DSSC_FAULT: begin
				if (fault_reset_i && !fault_i) begin
					state_next = DSSC_SW_DISABLED;
				end
			end
			default: state_next = DSSC_NOT_READY;
		endcase
		if (fault_i && state_reg != DSSC_FAULT_REACT && state_reg != DSSC_FAULT) begin
			state_next = DSSC_FAULT_REACT;
			act = fr_act;
			ramp_start = 1'b1;
		end
	end

	assign ramp_coast = (act == DSSC_STOP_COAST);
	assign ramp_time = (act == DSSC_STOP_SLOW) ? slow_decel_time_ms_reg
		: fast_stop_time_ms_reg;

	// Shared ramp generator for quick stop and fault reaction
	dssc_ramp #(
		.MS_CYCLES(MS_CYCLES),
		.SPEED_W(SPEED_W)
	) u_ramp (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.start_i(ramp_start),
		.coast_i(ramp_coast),
		.time_ms_i(ramp_time),
		.speed_i(speed_i),
		.speed_o(ramp_speed),
		.busy_o(ramp_busy),
		.done_o(ramp_done)
	);

	// State register; power-on reset lands in not ready
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= DSSC_NOT_READY;
		end else begin
			state_reg <= state_next;
		end
	end

	// Remember whether this quick stop keeps the drive enabled
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			qs_hold_reg <= 1'b0;
		end else if (ramp_start && state_next == DSSC_QSTOP) begin
			qs_hold_reg <= (quick_stop_option_reg == 16'h0003)
				|| (quick_stop_option_reg == 16'h0004);
		end
	end

	// Writable objects; the status word itself is read-only
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			slow_decel_time_ms_reg <= DSSC_TIME_RST;
			fast_stop_time_ms_reg <= DSSC_TIME_RST;
			quick_stop_option_reg <= DSSC_OPT_RST;
			fault_reaction_option_reg <= DSSC_OPT_RST;
		end else if (od_wr_i) begin
			case (od_index_i)
				DSSC_IDX_SLOW: slow_decel_time_ms_reg <= od_wdata_i;
				DSSC_IDX_FAST: fast_stop_time_ms_reg <= od_wdata_i;
				DSSC_IDX_QSOPT: quick_stop_option_reg <= od_wdata_i[15:0];
				DSSC_IDX_FROPT: fault_reaction_option_reg <= od_wdata_i[15:0];
				default: ;
			endcase
		end
	end

	// Status word composition from state and mode feedback
	always_comb begin
		sw_next = 16'h0000;
		case (state_reg)
			DSSC_NOT_READY: sw_next[7:0] = 8'h00;
			DSSC_SW_DISABLED: sw_next[7:0] = 8'h40;
			DSSC_READY: sw_next[7:0] = 8'h21;
			DSSC_SWITCHED_ON: sw_next[7:0] = 8'h23;
			DSSC_OP_ENABLED: sw_next[7:0] = 8'h27;
			DSSC_QSTOP: sw_next[7:0] = 8'h07;
			DSSC_FAULT_REACT: sw_next[7:0] = 8'h0f;
			DSSC_FAULT: sw_next[7:0] = 8'h08;
			default: sw_next[7:0] = 8'h00;
		endcase
		// Voltage present whenever the power stage is on
		sw_next[4] = (state_reg == DSSC_SWITCHED_ON) || (state_reg == DSSC_OP_ENABLED)
			|| (state_reg == DSSC_QSTOP) || (state_reg == DSSC_FAULT_REACT);
		sw_next[DSSC_SB_WARN] = fb_i.warning;
		sw_next[DSSC_SB_TARGET] = fb_i.target_reached;
		case (fb_i.mode)
			DSSC_MODE_PP: begin
				sw_next[DSSC_SB_MODE12] = fb_i.setpoint_ack;
				sw_next[DSSC_SB_MODE13] = fb_i.following_error;
			end
			DSSC_MODE_HM: begin
				sw_next[DSSC_SB_MODE12] = fb_i.homing_done;
				sw_next[DSSC_SB_MODE13] = fb_i.homing_error;
			end
			DSSC_MODE_IP: sw_next[DSSC_SB_MODE12] = fb_i.interp_active;
			DSSC_MODE_PV: sw_next[DSSC_SB_MODE12] = fb_i.zero_speed;
			default: ;
		endcase
	end

	// Registered status and power stage outputs
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_word_o <= 16'h0000;
			power_on_o <= 1'b0;
			brake_ramp_o <= 1'b0;
			speed_limit_o <= '0;
		end else begin
			status_word_o <= sw_next;
			// Coasting cuts power at once; ramps keep torque until speed is zero
			power_on_o <= (state_reg == DSSC_OP_ENABLED)
				|| ((state_reg == DSSC_QSTOP) && (ramp_busy || qs_hold_reg))
				|| ((state_reg == DSSC_FAULT_REACT) && ramp_busy);
			brake_ramp_o <= ramp_busy;
			speed_limit_o <= ramp_busy ? ramp_speed : speed_i;
		end
	end

	// Read side; unknown index acknowledges with an error flag
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			od_rdata_o <= 32'h0000_0000;
			od_ack_o <= 1'b0;
			od_err_o <= 1'b0;
		end else begin
			od_ack_o <= od_rd_i || od_wr_i;
			od_err_o <= 1'b0;
			od_rdata_o <= 32'h0000_0000;
			if (od_rd_i) begin
				case (od_index_i)
					DSSC_IDX_STATUS: od_rdata_o <= {16'h0000, sw_next};
					DSSC_IDX_SLOW: od_rdata_o <= slow_decel_time_ms_reg;
					DSSC_IDX_FAST: od_rdata_o <= fast_stop_time_ms_reg;
					DSSC_IDX_QSOPT: od_rdata_o <= {16'h0000, quick_stop_option_reg};
					DSSC_IDX_FROPT: od_rdata_o <= {16'h0000, fault_reaction_option_reg};
					default: od_err_o <= 1'b1;
				endcase
			end else if (od_wr_i) begin
				case (od_index_i)
					DSSC_IDX_CTRL, DSSC_IDX_SLOW, DSSC_IDX_FAST,
					DSSC_IDX_QSOPT, DSSC_IDX_FROPT: od_err_o <= 1'b0;
					default: od_err_o <= 1'b1;
				endcase
			end
		end
	end
endmodule

// ### include/dssc_pkg.sv
// Shared constants and types for the drive status and stop control block.
// Assumes an object-dictionary access port that presents index, data and strobes.
package dssc_pkg;
	// Object dictionary indices
	localparam logic [15:0] DSSC_IDX_CTRL = 16'h6040;
	localparam logic [15:0] DSSC_IDX_STATUS = 16'h6041;
	localparam logic [15:0] DSSC_IDX_SLOW = 16'h6050;
	localparam logic [15:0] DSSC_IDX_FAST = 16'h6051;
	localparam logic [15:0] DSSC_IDX_QSOPT = 16'h605a;
	localparam logic [15:0] DSSC_IDX_FROPT = 16'h605e;
	// Reset values
	localparam logic [31:0] DSSC_TIME_RST = 32'h0000_0000;
	localparam logic [15:0] DSSC_OPT_RST = 16'h0000;
	// Control word command values
	localparam logic [15:0] DSSC_CW_SHUTDOWN = 16'h0006;
	localparam logic [15:0] DSSC_CW_SWITCH_ON = 16'h0007;
	localparam logic [15:0] DSSC_CW_ENABLE = 16'h000f;
	localparam logic [15:0] DSSC_CW_QSTOP = 16'h0002;
	// Status bit positions
	localparam int DSSC_SB_WARN = 7;
	localparam int DSSC_SB_TARGET = 10;
	localparam int DSSC_SB_MODE12 = 12;
	localparam int DSSC_SB_MODE13 = 13;
	// Operating modes as reported by the mode display object
	localparam logic [7:0] DSSC_MODE_PP = 8'h01;
	localparam logic [7:0] DSSC_MODE_PV = 8'h03;
	localparam logic [7:0] DSSC_MODE_HM = 8'h06;
	localparam logic [7:0] DSSC_MODE_IP = 8'h07;
	// Timing: one millisecond tick at 250 MHz
	localparam int DSSC_CLK_MHZ = 250;
	localparam int DSSC_MS_US = 1000;
	localparam int DSSC_MS_CYCLES = DSSC_CLK_MHZ * DSSC_MS_US;
	// Drive states
	typedef enum logic [2:0] {
		DSSC_NOT_READY = 3'b000,
		DSSC_SW_DISABLED = 3'b001,
		DSSC_READY = 3'b010,
		DSSC_SWITCHED_ON = 3'b011,
		DSSC_OP_ENABLED = 3'b100,
		DSSC_QSTOP = 3'b101,
		DSSC_FAULT_REACT = 3'b110,
		DSSC_FAULT = 3'b111
	} dssc_state_t;
	// Stop actions
	typedef enum logic [1:0] {
		DSSC_STOP_COAST = 2'b00,
		DSSC_STOP_FAST = 2'b01,
		DSSC_STOP_SLOW = 2'b10
	} dssc_stop_t;
	// Process feedback from the motion core
	typedef struct packed {
		logic [7:0] mode;
		logic target_reached;
		logic setpoint_ack;
		logic homing_done;
		logic homing_error;
		logic interp_active;
		logic zero_speed;
		logic following_error;
		logic warning;
	} dssc_fb_t;
endpackage

// ### verilog/dssc_ramp.sv
// Speed ramp to zero over a time given in milliseconds.
// Assumes a start pulse with the time and the speed to ramp down from.
`timescale 1ns/1ps
module dssc_ramp
	import dssc_pkg::*;
#(
	parameter int MS_CYCLES = DSSC_MS_CYCLES,
	parameter int SPEED_W = 16
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Control
	input wire logic start_i,
	input wire logic coast_i,
	input wire logic [31:0] time_ms_i,
	input wire logic [SPEED_W-1:0] speed_i,
	// Result
	output logic [SPEED_W-1:0] speed_o,
	output logic busy_o,
	output logic done_o
);
	localparam int TW = $clog2(MS_CYCLES + 1);
	logic [TW-1:0] tick_reg; // Millisecond prescaler
	logic [31:0] ms_left_reg; // Milliseconds remaining
	logic [SPEED_W-1:0] step_reg; // Speed drop per millisecond
	logic ms_tick;

	assign ms_tick = (tick_reg == TW'(MS_CYCLES - 1));

	// Prescaler runs only while ramping, so each ramp starts on a whole millisecond
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_reg <= '0;
		end else if (!busy_o || ms_tick) begin
			tick_reg <= '0;
		end else begin
			tick_reg <= tick_reg + TW'(1);
		end
	end

	// Linear ramp; a zero time or a coast drops speed at once
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			speed_o <= '0;
			ms_left_reg <= '0;
			step_reg <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				if (coast_i || time_ms_i == 32'h0000_0000) begin
					// Coasting removes torque, so commanded speed goes straight to zero
					speed_o <= '0;
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					speed_o <= speed_i;
					ms_left_reg <= time_ms_i;
					// Integer step truncates; the final millisecond clears the rest
					step_reg <= SPEED_W'(32'(speed_i) / time_ms_i);
					busy_o <= 1'b1;
				end
			end else if (busy_o && ms_tick) begin
				if (ms_left_reg <= 32'h0000_0001 || speed_o <= step_reg) begin
					speed_o <= '0;
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					speed_o <= speed_o - step_reg;
					ms_left_reg <= ms_left_reg - 32'h0000_0001;
				end
			end
		end
	end
endmodule

// ### dv/dssc_top_sva.sv
// Concurrent checks on the status word and command ports of the drive block.
// Assumes one clock and the active-low asynchronous reset of dssc_top.
`timescale 1ns/1ps
module dssc_top_sva
	import dssc_pkg::*;
#(
	parameter int MS_CYCLES = DSSC_MS_CYCLES,
	parameter int SPEED_W = 16
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Object port
	input wire logic od_wr_i,
	input wire logic od_rd_i,
	input wire logic [15:0] od_index_i,
	input wire logic [31:0] od_wdata_i,
	input wire logic od_ack_o,
	input wire logic od_err_o,
	// Events and status
	input wire logic fault_i,
	input wire dssc_fb_t fb_i,
	input wire logic [15:0] status_word_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Short alias for the status word
	logic [15:0] sw;
	assign sw = status_word_o;
	chk_top_bits_zero: assert property (sw[15:14] == 2'b00)
		else $error("status bits 15:14 not zero");
	chk_low_state_legal: assert property (
		sw[6:0] inside {7'h00, 7'h40, 7'h21, 7'h33, 7'h37, 7'h17, 7'h1f, 7'h08})
		else $error("status low bits not a legal state");
	// Stable guard keeps these true for a latency of one or two cycles
	chk_warn_follows: assert property (
		$stable(fb_i.warning) |=> sw[7] == $past(fb_i.warning))
		else $error("warning bit does not follow feedback");
	chk_target_bit: assert property (
		$stable(fb_i.target_reached) |=> sw[10] == $past(fb_i.target_reached))
		else $error("target bit does not follow feedback");
	chk_pos_mode_bits: assert property (
		$stable(fb_i) && fb_i.mode == DSSC_MODE_PP |=>
		sw[13:12] == {$past(fb_i.following_error), $past(fb_i.setpoint_ack)})
		else $error("position mode bits wrong");
	chk_fault_entry: assert property ($rose(fault_i) |-> ##[1:3] sw[3])
		else $error("fault not shown in time");
	chk_fault_hold: assert property (fault_i && sw[3] |=> sw[3])
		else $error("fault left while fault present");
	chk_qstop_entry: assert property (
		od_wr_i && od_index_i == DSSC_IDX_CTRL && od_wdata_i[15:0] == DSSC_CW_QSTOP
		&& sw[6:0] == 7'h37 && !$past(od_wr_i) && !fault_i |-> ##[1:2] sw[6:0] == 7'h17)
		else $error("quick stop not shown");
	chk_enable_step: assert property (
		od_wr_i && od_index_i == DSSC_IDX_CTRL && od_wdata_i[15:0] == DSSC_CW_ENABLE
		&& sw[6:0] == 7'h33 && !$past(od_wr_i) && !fault_i |-> ##[1:2] sw[6:0] == 7'h37)
		else $error("enable not shown");
	chk_status_ro: assert property (
		od_wr_i && !od_rd_i && od_index_i == DSSC_IDX_STATUS |=> od_ack_o && od_err_o)
		else $error("status write not refused");
	// Main scenarios reached
	cov_qstop: cover property (sw[6:0] == 7'h17);
	cov_fault: cover property (sw[6:0] == 7'h08);
	cov_react: cover property (sw[6:0] == 7'h1f);
endmodule

bind dssc_top dssc_top_sva #(.MS_CYCLES(MS_CYCLES), .SPEED_W(SPEED_W)) u_sva (
	.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .od_wr_i(od_wr_i), .od_rd_i(od_rd_i),
	.od_index_i(od_index_i), .od_wdata_i(od_wdata_i), .od_ack_o(od_ack_o),
	.od_err_o(od_err_o), .fault_i(fault_i), .fb_i(fb_i), .status_word_o(status_word_o));

// ### dv/dssc_master.sv
// Master station model: one-cycle strobes on the object port.
// Assumes requests launch at the falling edge; answer comes one edge later.
`timescale 1ns/1ps
module dssc_master (
	// Clock
	input wire logic core_clk_i,
	// Object port
	output logic od_wr_o,
	output logic od_rd_o,
	output logic [15:0] od_index_o,
	output logic [31:0] od_wdata_o,
	input wire logic [31:0] od_rdata_i,
	input wire logic od_ack_i,
	input wire logic od_err_i
);
	initial begin
		od_wr_o = 1'b0;
		od_rd_o = 1'b0;
		od_index_o = 16'h0000;
		od_wdata_o = 32'h0000_0000;
	end
	// One access; released lines show the inverse so stale values cannot pass
	task automatic access(input logic rd, input logic [15:0] idx, input logic [31:0] d,
		output logic [31:0] q, output logic ack, output logic err);
		@(negedge core_clk_i);
		od_rd_o = rd;
		od_wr_o = !rd;
		od_index_o = idx;
		od_wdata_o = d;
		@(negedge core_clk_i);
		q = od_rdata_i;
		ack = od_ack_i;
		err = od_err_i;
		od_rd_o = 1'b0;
		od_wr_o = 1'b0;
		od_index_o = ~idx;
		od_wdata_o = ~d;
	endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for the drive status and stop block.
// Assumes the master model owns the object port; the bench drives events.
`timescale 1ns/1ps
module tb;
	import dssc_pkg::*;
	localparam int MS = 10;
	localparam int FT = 2;
	localparam int ST = 3;
	logic core_clk_i, reset_n_i, wr, rd, ack, err, init_done, fault, fault_rst, pwr, ramp;
	logic [15:0] idx, sw, speed, lim;
	logic [31:0] wd, rdat, q, rv; // rv: random time value, kept apart from the driven bus
	logic a, e, react;
	logic [15:0] mid; // Speed limit seen a little after the first ramp millisecond
	dssc_fb_t fb;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cnt;
	dssc_top #(.MS_CYCLES(MS)) dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.od_wr_i(wr), .od_rd_i(rd), .od_index_i(idx), .od_wdata_i(wd), .od_rdata_o(rdat),
		.od_ack_o(ack), .od_err_o(err), .init_done_i(init_done), .fault_i(fault),
		.fault_reset_i(fault_rst), .fb_i(fb), .speed_i(speed), .power_on_o(pwr),
		.brake_ramp_o(ramp), .speed_limit_o(lim), .status_word_o(sw));
	dssc_master m (.core_clk_i(core_clk_i), .od_wr_o(wr), .od_rd_o(rd), .od_index_o(idx),
		.od_wdata_o(wd), .od_rdata_i(rdat), .od_ack_i(ack), .od_err_i(err));
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Count ramp cycles until the ramp has ended; a stuck ramp ends the run
	task automatic wait_ramp();
		cnt = 0;
		react = 1'b0;
		mid = 16'h0000;
		for (int i = 0; i < 400; i++) begin
			@(negedge core_clk_i);
			if (sw[6:0] === 7'h1f)
				react = 1'b1;
			if (ramp === 1'b1)
				cnt++;
			else if (i > 2)
				return;
			// Past the first millisecond step, well before the second
			if (ramp === 1'b1 && cnt == MS + 2)
				mid = lim;
		end
		check("ramp end", 0, 1);
		final_report();
	endtask
	// Ramp length fits the selected time, with slack for prescaler start
	function automatic logic ramp_ok(input int t, input int c);
		return (t == 0) ? (c <= 2) : (c >= t * MS - 2 && c <= t * MS + 3);
	endfunction
	function automatic logic [15:0] exp_sw(input dssc_fb_t f);
		logic [15:0] s;
		s = 16'h0037;
		s[7] = f.warning;
		s[10] = f.target_reached;
		case (f.mode)
			DSSC_MODE_PP: s[13:12] = {f.following_error, f.setpoint_ack};
			DSSC_MODE_HM: s[13:12] = {f.homing_error, f.homing_done};
			DSSC_MODE_IP: s[12] = f.interp_active;
			DSSC_MODE_PV: s[12] = f.zero_speed;
			default: ;
		endcase
		return s;
	endfunction
	// Command walk 6, 7, 15 from switch-on-disabled
	task automatic go_enabled();
		logic [15:0] cws [3] = '{DSSC_CW_SHUTDOWN, DSSC_CW_SWITCH_ON, DSSC_CW_ENABLE};
		logic [6:0] st [3] = '{7'h21, 7'h33, 7'h37};
		for (int i = 0; i < 3; i++) begin
			m.access(1'b0, DSSC_IDX_CTRL, {16'h0, cws[i]}, q, a, e);
			@(negedge core_clk_i);
			check("state", sw[6:0], st[i]);
		end
	endtask
	initial begin
		logic [15:0] ridx [4] = '{DSSC_IDX_SLOW, DSSC_IDX_FAST, DSSC_IDX_QSOPT, DSSC_IDX_FROPT};
		logic [7:0] modes [5] = '{DSSC_MODE_PP, DSSC_MODE_PV, DSSC_MODE_HM, DSSC_MODE_IP, 8'h04};
		int fo [4] = '{0, 1, 2, 9};
		int t;
		reset_n_i = 1'b0;
		{init_done, fault, fault_rst} = 3'b000;
		fb = '0;
		speed = 16'h0000;
		void'($urandom(97));
		repeat (5) @(negedge core_clk_i);
		reset_n_i = 1'b1;
		@(negedge core_clk_i);
		check("not ready", sw, 16'h0000);
		foreach (ridx[i]) begin
			m.access(1'b1, ridx[i], 32'h0, q, a, e);
			check("reset value", q, 32'h0);
		end
		m.access(1'b1, 16'h6061, 32'h0, q, a, e);
		check("unmapped err", {a, e}, 2'b11);
		m.access(1'b0, DSSC_IDX_STATUS, 32'h5, q, a, e);
		check("status write err", {a, e}, 2'b11);
		rv = $urandom();
		m.access(1'b0, DSSC_IDX_SLOW, rv, q, a, e);
		m.access(1'b1, DSSC_IDX_SLOW, 32'h0, q, a, e);
		check("slow time", q, rv);
		m.access(1'b0, DSSC_IDX_FAST, FT, q, a, e);
		m.access(1'b0, DSSC_IDX_SLOW, ST, q, a, e);
		m.access(1'b0, DSSC_IDX_QSOPT, 32'hffff_0004, q, a, e);
		m.access(1'b1, DSSC_IDX_QSOPT, 32'h0, q, a, e);
		check("option width", q, 32'h4);
		$display("test registers done");
		init_done = 1'b1;
		repeat (3) @(negedge core_clk_i);
		check("switch-on disabled", sw, 16'h0040);
		go_enabled();
		m.access(1'b1, DSSC_IDX_STATUS, 32'h0, q, a, e);
		check("status read", q, 32'h37);
		repeat (24) begin
			fb = dssc_fb_t'(16'($urandom()));
			fb.mode = modes[$urandom_range(4)];
			repeat (3) @(negedge core_clk_i);
			check("status bits", sw & 16'hf4ff, exp_sw(fb));
		end
		fb = '0;
		$display("test status bits done");
		for (int o = 0; o < 6; o++) begin
			m.access(1'b0, DSSC_IDX_QSOPT, o, q, a, e);
			speed = 16'h0100 | 16'($urandom());
			m.access(1'b0, DSSC_IDX_CTRL, {16'h0, DSSC_CW_QSTOP}, q, a, e);
			@(negedge core_clk_i);
			check("qstop state", sw[6:0], 7'h17);
			check("ramp start speed", lim, speed);
			wait_ramp();
			t = (o == 1 || o == 3) ? FT : (o == 2 || o == 4) ? ST : 0;
			check("qstop ramp", ramp_ok(t, cnt), 1'b1);
			if (t != 0)
				check("ramp speed", mid, speed - speed / t);
			repeat (2) @(negedge core_clk_i);
			if (o == 3 || o == 4) begin
				check("stay enabled", {pwr, sw[6:0]}, 8'h97);
				m.access(1'b0, DSSC_IDX_CTRL, {16'h0, DSSC_CW_ENABLE}, q, a, e);
				repeat (2) @(negedge core_clk_i);
				check("re-enabled", sw[6:0], 7'h37);
			end else begin
				check("after qstop", sw[6:0], 7'h40);
				go_enabled();
			end
		end
		$display("test quick stop done");
		foreach (fo[i]) begin
			m.access(1'b0, DSSC_IDX_FROPT, fo[i], q, a, e);
			fault = 1'b1;
			wait_ramp();
			t = (fo[i] == 1) ? FT : (fo[i] == 2) ? ST : 0;
			check("fault ramp", ramp_ok(t, cnt), 1'b1);
			if (t != 0) begin
				check("reaction shown", react, 1'b1);
				check("ramp speed", mid, speed - speed / t);
			end
			// Settled fault shows one edge after the ramp flag drops
			repeat (2) @(negedge core_clk_i);
			check("fault state", sw[6:0], 7'h08);
			fault = 1'b0;
			fault_rst = 1'b1;
			@(negedge core_clk_i);
			fault_rst = 1'b0;
			repeat (2) @(negedge core_clk_i);
			check("fault cleared", sw[6:0], 7'h40);
			go_enabled();
		end
		$display("test fault reaction done");
		final_report();
	end
endmodule
